// file: rtl/pwr_ctl_pkg.sv
// Contract
// R01: In soft-off, a press under four seconds moves to working.
// R02: In working, a press under four seconds moves to sleeping.
// R03: In working, a press over six seconds forces soft-off.
// R04: In sleeping, a press under four seconds wakes to working.
// R05: In sleeping, a press over six seconds moves to soft-off.
// R06: A closed intrusion switch flags an intrusion event.
// R07: Five supply voltages are checked against their window; excursions flagged.
// R08: Thermal readings steer three fans: speed, on or off.
// R09: Host software commands power states; controller moves only on command or press.
// R10: Switch debounced, press timed; release between four and six seconds does nothing.
package pwr_ctl_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SHORT_PRESS_MS = 4000;
  localparam int unsigned LONG_PRESS_MS = 6000;
  localparam int unsigned DEBOUNCE_US = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam longint unsigned SHORT_CYC = longint'(SHORT_PRESS_MS) * 1000 * CLK_MHZ;
  localparam longint unsigned LONG_CYC = longint'(LONG_PRESS_MS) * 1000 * CLK_MHZ;
  localparam int unsigned NUM_RAILS = 5;
  localparam int unsigned NUM_FANS = 3;
  localparam int unsigned TEMP_W = 8;
  localparam int unsigned VOLT_W = 10;
  localparam int unsigned DUTY_W = 8;
  localparam logic [DUTY_W-1:0] DUTY_OFF = 8'h00;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_WORK,
    CMD_SLEEP,
    CMD_OFF
  } host_cmd_t;

  typedef struct packed {
    logic [VOLT_W-1:0] low;
    logic [VOLT_W-1:0] high;
  } volt_window_t;

  typedef struct packed {
    logic [TEMP_W-1:0] t_off;
    logic [TEMP_W-1:0] t_full;
  } fan_curve_t;
endpackage : pwr_ctl_pkg

// file: rtl/power_switch_state_control.sv
`timescale 1ns/100ps
`default_nettype none
module power_switch_state_control #(
  parameter longint unsigned SHORT_CYC = pwr_ctl_pkg::SHORT_CYC,
  parameter longint unsigned LONG_CYC = pwr_ctl_pkg::LONG_CYC,
  parameter int unsigned DEBOUNCE_CYC = pwr_ctl_pkg::DEBOUNCE_CYC
) (
  input wire logic clock, // Standby clock
  input wire logic nrst, // Standby reset, active low
  input wire logic switch_n, // Power switch pin, low while pressed
  input wire logic intrusion_closed, // Intrusion switch pin, high when closed
  input wire pwr_ctl_pkg::host_cmd_t host_cmd, // Host power command, one-cycle
  input wire logic [pwr_ctl_pkg::NUM_RAILS*pwr_ctl_pkg::VOLT_W-1:0] rail_level, // Rail readings
  input wire pwr_ctl_pkg::volt_window_t [pwr_ctl_pkg::NUM_RAILS-1:0] rail_window, // Limits
  input wire logic [pwr_ctl_pkg::NUM_FANS*pwr_ctl_pkg::TEMP_W-1:0] fan_temp, // Temps
  input wire pwr_ctl_pkg::fan_curve_t [pwr_ctl_pkg::NUM_FANS-1:0] fan_curve, // Fan curves
  input wire logic intrusion_clear, // Clears intrusion flag
  output logic working, // System in working state
  output logic sleeping, // System in sleeping state
  output logic soft_off, // System in soft-off state
  output logic intrusion_flag, // Sticky intrusion event
  output logic [pwr_ctl_pkg::NUM_RAILS-1:0] rail_fault, // Rail outside window
  output logic [pwr_ctl_pkg::NUM_FANS*pwr_ctl_pkg::DUTY_W-1:0] fan_duty // PWM duty per fan
);
  localparam int CW = 40;
  typedef enum logic [1:0] {ST_OFF, ST_WORK, ST_SLEEP} pstate_t;

  // Press counter must reach the long limit without saturating first
  if (LONG_CYC <= SHORT_CYC || SHORT_CYC == 0 || DEBOUNCE_CYC == 0 ||
      LONG_CYC >= (64'h1 << CW)) begin : g_bad_timing
    $error("Press timing parameters inconsistent");
  end

  // Pin synchronisers
  logic [1:0] sw_sync_reg;
  logic [1:0] intr_sync_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sw_sync_reg <= 2'h3;
      intr_sync_reg <= 2'h0;
    end else begin
      sw_sync_reg <= {sw_sync_reg[0], switch_n};
      intr_sync_reg <= {intr_sync_reg[0], intrusion_closed};
    end
  end
  wire logic sw_raw = ~sw_sync_reg[1];
  wire logic intr_raw = intr_sync_reg[1];

  // R10 debounce filter
  logic pressed_reg;
  logic [31:0] db_cnt_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pressed_reg <= 1'b0;
      db_cnt_reg <= 32'h0;
    end else if (sw_raw == pressed_reg) begin
      db_cnt_reg <= 32'h0;
    end else if (db_cnt_reg >= DEBOUNCE_CYC - 1) begin
      pressed_reg <= sw_raw;
      db_cnt_reg <= 32'h0;
    end else begin
      db_cnt_reg <= db_cnt_reg + 32'h1;
    end
  end

  // R10 press duration
  logic [CW-1:0] press_cnt_reg;
  logic long_done_reg;
  wire logic release_evt = (db_cnt_reg >= DEBOUNCE_CYC - 1) && !sw_raw && pressed_reg;
  wire logic short_release = release_evt && (press_cnt_reg < CW'(SHORT_CYC));
  wire logic long_hit = pressed_reg && !long_done_reg && (press_cnt_reg >= CW'(LONG_CYC));
  always_ff @(posedge clock) begin
    if (!nrst) begin
      press_cnt_reg <= '0;
      long_done_reg <= 1'b0;
    end else if (!pressed_reg) begin
      press_cnt_reg <= '0;
      long_done_reg <= 1'b0;
    end else begin
      if (press_cnt_reg != '1)
        press_cnt_reg <= press_cnt_reg + CW'(1);
      if (long_hit)
        long_done_reg <= 1'b1;
    end
  end

  // Power state machine
  pstate_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_OFF: begin
        // R01 short press powers on
        if (short_release)
          st_next = ST_WORK;
        // R09 host command
        else if (host_cmd == pwr_ctl_pkg::CMD_WORK)
          st_next = ST_WORK;
      end
      ST_WORK: begin
        // R03 long press fail-safe off
        if (long_hit)
          st_next = ST_OFF;
        // R02 short press to sleep
        else if (short_release)
          st_next = ST_SLEEP;
        else if (host_cmd == pwr_ctl_pkg::CMD_SLEEP)
          st_next = ST_SLEEP;
        else if (host_cmd == pwr_ctl_pkg::CMD_OFF)
          st_next = ST_OFF;
      end
      ST_SLEEP: begin
        // R05 long press to off
        if (long_hit)
          st_next = ST_OFF;
        // R04 short press wakes
        else if (short_release)
          st_next = ST_WORK;
        else if (host_cmd == pwr_ctl_pkg::CMD_WORK)
          st_next = ST_WORK;
        else if (host_cmd == pwr_ctl_pkg::CMD_OFF)
          st_next = ST_OFF;
      end
      default: st_next = ST_OFF;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= ST_OFF;
      working <= 1'b0;
      sleeping <= 1'b0;
      soft_off <= 1'b1;
    end else begin
      st_reg <= st_next;
      working <= (st_next == ST_WORK);
      sleeping <= (st_next == ST_SLEEP);
      soft_off <= (st_next == ST_OFF);
    end
  end

  // R06 intrusion flag, set wins over clear
  always_ff @(posedge clock) begin
    if (!nrst)
      intrusion_flag <= 1'b0;
    else if (intr_raw)
      intrusion_flag <= 1'b1;
    else if (intrusion_clear)
      intrusion_flag <= 1'b0;
  end

  // R07 rail window check
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rail_fault <= '0;
    end else begin
      for (int i = 0; i < pwr_ctl_pkg::NUM_RAILS; i++) begin
        rail_fault[i] <= (rail_level[i*pwr_ctl_pkg::VOLT_W +: pwr_ctl_pkg::VOLT_W]
                          < rail_window[i].low) ||
                         (rail_level[i*pwr_ctl_pkg::VOLT_W +: pwr_ctl_pkg::VOLT_W]
                          > rail_window[i].high);
      end
    end
  end

  // Linear ramp between off and full temperature
  function automatic logic [pwr_ctl_pkg::DUTY_W-1:0] fan_law(
    input logic [pwr_ctl_pkg::TEMP_W-1:0] t,
    input pwr_ctl_pkg::fan_curve_t c
  );
    logic [15:0] span;
    logic [15:0] pos;
    span = 16'(c.t_full) - 16'(c.t_off);
    pos = 16'(t) - 16'(c.t_off);
    if (t <= c.t_off)
      return pwr_ctl_pkg::DUTY_OFF;
    else if (t >= c.t_full)
      return pwr_ctl_pkg::DUTY_FULL;
    else
      return pwr_ctl_pkg::DUTY_W'((pos * 16'(pwr_ctl_pkg::DUTY_FULL)) / span);
  endfunction : fan_law

  // R08 closed-loop fan control; fans only run while working
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fan_duty <= '0;
    end else begin
      for (int f = 0; f < pwr_ctl_pkg::NUM_FANS; f++) begin
        fan_duty[f*pwr_ctl_pkg::DUTY_W +: pwr_ctl_pkg::DUTY_W] <= (st_reg == ST_WORK) ?
          fan_law(fan_temp[f*pwr_ctl_pkg::TEMP_W +: pwr_ctl_pkg::TEMP_W], fan_curve[f]) :
          pwr_ctl_pkg::DUTY_OFF;
      end
    end
  end

  // Assertions
  sequence short_in_state(pstate_t s);
    st_reg == s && short_release && !long_hit;
  endsequence

  off_short_on_a: assert property (@(posedge clock) disable iff (!nrst) // R01
    short_in_state(ST_OFF) |=> working) else $error("Short press in off did not power on");
  work_short_sleep_a: assert property (@(posedge clock) disable iff (!nrst) // R02
    short_in_state(ST_WORK) |=> sleeping) else $error("Short press in work did not sleep");
  work_long_off_a: assert property (@(posedge clock) disable iff (!nrst) // R03
    (st_reg == ST_WORK && long_hit) |=> soft_off) else $error("Long press did not power off");
  sleep_short_wake_a: assert property (@(posedge clock) disable iff (!nrst) // R04
    short_in_state(ST_SLEEP) |=> working) else $error("Short press did not wake");
  sleep_long_off_a: assert property (@(posedge clock) disable iff (!nrst) // R05
    (st_reg == ST_SLEEP && long_hit) |=> soft_off) else $error("Long press in sleep not off");
  intrusion_flag_a: assert property (@(posedge clock) disable iff (!nrst) // R06
    intr_raw |=> intrusion_flag) else $error("Intrusion not flagged");
  rail_fault_a: assert property (@(posedge clock) disable iff (!nrst) // R07
    (rail_level[pwr_ctl_pkg::VOLT_W-1:0] > rail_window[0].high) |=> rail_fault[0])
    else $error("Rail excursion not flagged");
  fan_off_a: assert property (@(posedge clock) disable iff (!nrst) // R08
    (st_reg != ST_WORK) |=> fan_duty == '0) else $error("Fan running outside working");
  no_spont_move_a: assert property (@(posedge clock) disable iff (!nrst) // R09
    (host_cmd == pwr_ctl_pkg::CMD_NONE && !short_release && !long_hit) |=> $stable(st_reg))
    else $error("State changed without command or press");
  mid_release_a: assert property (@(posedge clock) disable iff (!nrst) // R10
    (release_evt && !short_release && !long_hit && host_cmd == pwr_ctl_pkg::CMD_NONE)
    |=> $stable(st_reg)) else $error("Mid-length release moved state");
endmodule : power_switch_state_control
`default_nettype wire

// file: test/panel_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module panel_host_model (
  input wire logic clock, // Standby clock
  output logic switch_n, // Power switch, low while pressed
  output pwr_ctl_pkg::host_cmd_t host_cmd // Host command pulse
);
  initial begin
    switch_n = 1'b1;
    host_cmd = pwr_ctl_pkg::CMD_NONE;
  end
  task automatic press(input int n);
    @(posedge clock) switch_n <= 1'b0;
    repeat (n) @(posedge clock);
    switch_n <= 1'b1;
  endtask : press
  task automatic command(input pwr_ctl_pkg::host_cmd_t a, input pwr_ctl_pkg::host_cmd_t b);
    @(posedge clock) host_cmd <= a;
    @(posedge clock) host_cmd <= b;
    @(posedge clock) host_cmd <= pwr_ctl_pkg::CMD_NONE;
  endtask : command
endmodule : panel_host_model
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int SH = 100;
  localparam int LG = 150;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  wire logic switch_n;
  pwr_ctl_pkg::host_cmd_t host_cmd;
  logic intrusion_closed = 1'b0;
  logic intrusion_clear = 1'b0;
  logic [49:0] rail_level = '0;
  pwr_ctl_pkg::volt_window_t [4:0] rail_window = {5{10'h064, 10'h384}};
  pwr_ctl_pkg::fan_curve_t [2:0] fan_curve = {3{8'h40, 8'h80}};
  // Hot enough that a running fan sits at full duty
  logic [23:0] fan_temp = {3{8'hc8}};
  logic [7:0] lo, hi, tt;
  logic [23:0] exp_duty;
  logic working, sleeping, soft_off, intrusion_flag;
  logic [4:0] rail_fault;
  logic [23:0] fan_duty;
  logic [2:0] q[$];
  logic [2:0] st_prev = 3'b001;
  int miscompares = 0;
  int compares = 0;
  always #2 clock = ~clock;
  panel_host_model u_ph (.clock(clock), .switch_n(switch_n), .host_cmd(host_cmd));
  power_switch_state_control #(.SHORT_CYC(SH), .LONG_CYC(LG), .DEBOUNCE_CYC(4)) u_dut (
    .clock(clock), .nrst(nrst), .switch_n(switch_n), .intrusion_closed(intrusion_closed),
    .host_cmd(host_cmd), .rail_level(rail_level), .rail_window(rail_window),
    .fan_temp(fan_temp), .fan_curve(fan_curve), .intrusion_clear(intrusion_clear),
    .working(working), .sleeping(sleeping), .soft_off(soft_off),
    .intrusion_flag(intrusion_flag), .rail_fault(rail_fault), .fan_duty(fan_duty));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic settle(input logic on);
    int i;
    for (i = 0; i < 400 && q.size() != 0; i++) @(posedge clock);
    if (q.size() != 0) begin
      miscompares++;
      conclude();
    end
    // Quiet spell so a late spurious change is still caught
    repeat (20) @(posedge clock);
    chk("fan_duty", on ? {3{8'hff}} : 24'h0, fan_duty);
  endtask : settle
  // Any state change must match the oldest note; none pending means it is spurious
  always @(posedge clock) begin
    if (nrst && {working, sleeping, soft_off} !== st_prev) begin
      st_prev <= {working, sleeping, soft_off};
      if (q.size() == 0) chk("state", st_prev, {working, sleeping, soft_off});
      else chk("state", q.pop_front(), {working, sleeping, soft_off});
    end
  end
  initial begin
    void'($urandom(98));
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    chk("soft_off", 1'b1, soft_off);
    q.push_back(3'b100);
    u_ph.command(pwr_ctl_pkg::CMD_WORK, pwr_ctl_pkg::CMD_WORK);
    settle(1'b1);
    q.push_back(3'b010);
    q.push_back(3'b001);
    u_ph.command(pwr_ctl_pkg::CMD_SLEEP, pwr_ctl_pkg::CMD_OFF);
    settle(1'b0);
    // Short presses just under the limit, then one just over it
    for (int k = 0; k < 4; k++) begin
      if (k < 3) q.push_back(k == 1 ? 3'b010 : 3'b100);
      u_ph.press(k < 3 ? SH - 3 : SH + 3);
      settle(k != 1);
    end
    q.push_back(3'b001);
    u_ph.press(LG + 20);
    settle(1'b0);
    q.push_back(3'b100);
    q.push_back(3'b010);
    q.push_back(3'b001);
    u_ph.command(pwr_ctl_pkg::CMD_WORK, pwr_ctl_pkg::CMD_SLEEP);
    u_ph.press(LG + 20);
    settle(1'b0);
    q.push_back(3'b100);
    u_ph.command(pwr_ctl_pkg::CMD_WORK, pwr_ctl_pkg::CMD_NONE);
    settle(1'b1);
    // Random curves and temperatures walk the ramp, both ends included
    for (int k = 0; k < 8; k++) begin
      for (int f = 0; f < 3; f++) begin
        lo = 8'($urandom_range(127));
        hi = lo + 8'($urandom_range(127)) + 8'h01;
        tt = 8'($urandom_range(255));
        fan_curve[f] <= {lo, hi};
        fan_temp[8*f +: 8] <= tt;
        exp_duty[8*f +: 8] = tt <= lo ? 8'h00 : tt >= hi ? 8'hff :
          8'((32'(tt - lo) * 255) / 32'(hi - lo));
      end
      repeat (3) @(posedge clock);
      chk("fan_duty", exp_duty, fan_duty);
    end
    for (int k = 0; k < 8; k++) begin
      for (int r = 0; r < 5; r++) begin
        rail_level[10*r +: 10] <= k < 2 ? 10'(98 + 800 * k + r) : 10'($urandom_range(1023));
        rail_window[r] <= k < 2 ? {10'h064, 10'h384} :
          {10'($urandom_range(511)), 10'($urandom_range(1023, 512))};
      end
      repeat (3) @(posedge clock);
      for (int r = 0; r < 5; r++)
        chk("rail_fault", 24'(rail_level[10*r +: 10] < rail_window[r].low ||
            rail_level[10*r +: 10] > rail_window[r].high), 24'(rail_fault[r]));
    end
    intrusion_closed <= 1'b1;
    repeat (5) @(posedge clock);
    intrusion_clear <= 1'b1;
    @(posedge clock) intrusion_clear <= 1'b0;
    repeat (3) @(posedge clock);
    chk("intrusion_flag", 1'b1, intrusion_flag);
    intrusion_closed <= 1'b0;
    repeat (5) @(posedge clock);
    chk("intrusion_flag", 1'b1, intrusion_flag);
    intrusion_clear <= 1'b1;
    @(posedge clock) intrusion_clear <= 1'b0;
    repeat (3) @(posedge clock);
    chk("intrusion_flag", 1'b0, intrusion_flag);
    conclude();
  end
endmodule : tb
`default_nettype wire
